// ---- inc/dte_pkg.sv ----
// constants, types and helpers of the block transfer engine
// assumes: one 100 MHz clock, synchronous active-high reset, 32-bit word registers
package dte_pkg;
   localparam int          ADDR_W         = 32;
   // word index of each register; byte address is four times the index
   localparam logic [2:0]  IDX_SRC        = 3'h0;
   localparam logic [2:0]  IDX_DST        = 3'h1;
   localparam logic [2:0]  IDX_CRA        = 3'h2;
   localparam logic [2:0]  IDX_CRB        = 3'h3;
   localparam logic [2:0]  IDX_CTRL       = 3'h4;
   localparam logic [2:0]  IDX_STAT       = 3'h5;
   localparam int          CRA_HOLD_LSB   = 8;
   localparam int          CTRL_START_BIT = 0;
   localparam int          CTRL_AREA_BIT  = 1;
   localparam int          CTRL_SMODE_LSB = 2;
   localparam int          CTRL_DMODE_LSB = 4;
   localparam int          STAT_BUSY_BIT  = 0;
   localparam int          STAT_IRQ_BIT   = 1;
   localparam logic [31:0] RST_ADDR       = 32'h00000000;
   localparam logic [7:0]  RST_SIZE       = 8'h01;
   localparam logic [15:0] RST_BLOCKS     = 16'h0001;
   localparam logic [31:0] ADDR_STEP      = 32'h00000001;

   typedef enum logic [1:0] {
      AM_FIXED  = 2'h0,
      AM_INC    = 2'h1,
      AM_DEC    = 2'h2,
      AM_HOLD   = 2'h3
   } dte_amode_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN  = 2'h1,
      ST_WAIT = 2'h3,
      ST_FIN  = 2'h2
   } dte_state_e;

   typedef enum logic [1:0] {
      MV_IDLE = 2'h0,
      MV_RD   = 2'h1,
      MV_WR   = 2'h3
   } dte_mvstate_e;

   // next address after one unit for the given address mode
   function automatic logic [31:0] dte_step(input logic [31:0] a, input logic [1:0] m);
      case (m)
         AM_INC:  dte_step = a + ADDR_STEP;
         AM_DEC:  dte_step = a - ADDR_STEP;
         default: dte_step = a;
      endcase
   endfunction : dte_step
endpackage : dte_pkg

// ---- inc/dte_if.sv ----
// internal carriers: register access and one-unit move request
// assumes: both ends on the same clock
`timescale 1ns/1ps
interface dte_reg_if;
   logic        wrEn;
   logic [2:0]  idx;
   logic [31:0] wrData;
   logic [31:0] rdData;
   modport slv  (output wrEn, output idx, output wrData, input rdData);
   modport core (input wrEn, input idx, input wrData, output rdData);
endinterface : dte_reg_if

interface dte_unit_if;
   logic        go;
   logic [31:0] srcAddr;
   logic [31:0] dstAddr;
   logic        done;
   modport ctl (output go, output srcAddr, output dstAddr, input done);
   modport mov (input go, input srcAddr, input dstAddr, output done);
endinterface : dte_unit_if

// ---- rtl/dte_avs_regs.sv ----
// Avalon-MM slave front end with one wait state
// assumes: master holds its request until waitrequest is low
`timescale 1ns/1ps
module dte_avs_regs
   import dte_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [4:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWritedata,
   input  wire logic [3:0]  avsByteenable,
   output logic      [31:0] avsReaddata,
   output logic             avsWaitrequest,
   dte_reg_if.slv           regs
);
   logic        ackQ;
   logic        next_ackQ;
   logic [31:0] rdQ;
   logic [31:0] next_rdQ;
   logic        req;

   assign req = avsRead | avsWrite;

   always_comb begin
      next_ackQ = req & ~ackQ;
      next_rdQ  = rdQ;
      // read data captured in the wait cycle so it stands at the accepting edge
      if (avsRead && !ackQ) begin
         next_rdQ = regs.rdData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ackQ <= 1'b0;
         rdQ  <= 32'h00000000;
      end else begin
         ackQ <= next_ackQ;
         rdQ  <= next_rdQ;
      end
   end

   // byte lanes left out keep the register's current contents
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         regs.wrData[b*8 +: 8] = avsByteenable[b] ? avsWritedata[b*8 +: 8]
                                                  : regs.rdData[b*8 +: 8];
      end
   end

   assign regs.idx       = avsAddress[4:2];
   assign regs.wrEn      = avsWrite & ackQ;
   assign avsWaitrequest = req & ~ackQ;
   assign avsReaddata    = rdQ;
endmodule : dte_avs_regs

// ---- rtl/dte_unit_mover.sv ----
// moves one data unit: read at source, then write at destination
// assumes: memory port answers each held request with a one-cycle memAck
`timescale 1ns/1ps
module dte_unit_mover
   import dte_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input  wire logic              clk,
   input  wire logic              rst,
   dte_unit_if.mov                unit,
   output logic                   memRead,
   output logic                   memWrite,
   output logic      [31:0]       memAddr,
   output logic      [DATA_W-1:0] memWdata,
   input  wire logic [DATA_W-1:0] memRdata,
   input  wire logic              memAck
);
   dte_mvstate_e      st;
   dte_mvstate_e      next_st;
   logic [31:0]       addrQ;
   logic [31:0]       next_addrQ;
   logic [31:0]       dstQ;
   logic [31:0]       next_dstQ;
   logic [DATA_W-1:0] dataQ;
   logic [DATA_W-1:0] next_dataQ;

   always_comb begin
      next_st    = st;
      next_addrQ = addrQ;
      next_dstQ  = dstQ;
      next_dataQ = dataQ;
      case (st)
         MV_IDLE: begin
            if (unit.go) begin
               next_addrQ = unit.srcAddr;
               next_dstQ  = unit.dstAddr;
               next_st    = MV_RD;
            end
         end
         MV_RD: begin
            if (memAck) begin
               next_dataQ = memRdata;
               next_addrQ = dstQ;
               next_st    = MV_WR;
            end
         end
         MV_WR: begin
            if (memAck) begin
               next_st = MV_IDLE;
            end
         end
         default: next_st = MV_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st    <= MV_IDLE;
         addrQ <= RST_ADDR;
         dstQ  <= RST_ADDR;
         dataQ <= '0;
      end else begin
         st    <= next_st;
         addrQ <= next_addrQ;
         dstQ  <= next_dstQ;
         dataQ <= next_dataQ;
      end
   end

   assign memRead   = (st == MV_RD);
   assign memWrite  = (st == MV_WR);
   assign memAddr   = addrQ;
   assign memWdata  = dataQ;
   assign unit.done = (st == MV_WR) && memAck;
endmodule : dte_unit_mover

// ---- rtl/dte_top.sv ----
// block transfer engine: registers, block sequencing and unit moves
// assumes: Avalon-MM master on the register port; same-clock memory port
//
// The register addresses and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module dte_top
   import dte_pkg::*;
#(
   parameter int DATA_W = 16
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [4:0]        avsAddress,
   input  wire logic              avsRead,
   input  wire logic              avsWrite,
   input  wire logic [31:0]       avsWritedata,
   input  wire logic [3:0]        avsByteenable,
   output logic      [31:0]       avsReaddata,
   output logic                   avsWaitrequest,
   input  wire logic              actReq,
   output logic                   memRead,
   output logic                   memWrite,
   output logic      [31:0]       memAddr,
   output logic      [DATA_W-1:0] memWdata,
   input  wire logic [DATA_W-1:0] memRdata,
   input  wire logic              memAck,
   output logic                   cpuIrq
);
   dte_reg_if  regs ();
   dte_unit_if unit ();

   dte_state_e  st;
   dte_state_e  next_st;
   logic [31:0] srcAddr;
   logic [31:0] next_srcAddr;
   logic [31:0] dstAddr;
   logic [31:0] next_dstAddr;
   logic [31:0] blkSave;
   logic [31:0] next_blkSave;
   logic [7:0]  blockSizeHold;
   logic [7:0]  next_blockSizeHold;
   logic [7:0]  unitCnt;
   logic [7:0]  next_unitCnt;
   logic [15:0] blockCount;
   logic [15:0] next_blockCount;
   logic        areaIsDst;
   logic        next_areaIsDst;
   logic [1:0]  srcMode;
   logic [1:0]  next_srcMode;
   logic [1:0]  dstMode;
   logic [1:0]  next_dstMode;
   logic        irqFlag;
   logic        next_irqFlag;
   logic        goReq;
   logic        irqSet;

   dte_avs_regs u_regs (
      .clk            (clk),
      .rst            (rst),
      .avsAddress     (avsAddress),
      .avsRead        (avsRead),
      .avsWrite       (avsWrite),
      .avsWritedata   (avsWritedata),
      .avsByteenable  (avsByteenable),
      .avsReaddata    (avsReaddata),
      .avsWaitrequest (avsWaitrequest),
      .regs           (regs)
   );

   dte_unit_mover #(
      .DATA_W (DATA_W)
   ) u_mover (
      .clk      (clk),
      .rst      (rst),
      .unit     (unit),
      .memRead  (memRead),
      .memWrite (memWrite),
      .memAddr  (memAddr),
      .memWdata (memWdata),
      .memRdata (memRdata),
      .memAck   (memAck)
   );

   // register read view
   always_comb begin
      case (regs.idx)
         IDX_SRC:  regs.rdData = srcAddr;
         IDX_DST:  regs.rdData = dstAddr;
         IDX_CRA:  regs.rdData = {16'h0000, blockSizeHold, unitCnt};
         IDX_CRB:  regs.rdData = {16'h0000, blockCount};
         IDX_CTRL: regs.rdData = {26'h0000000, dstMode, srcMode, areaIsDst, 1'b0};
         IDX_STAT: regs.rdData = {30'h00000000, irqFlag, (st != ST_IDLE)};
         default:  regs.rdData = 32'h00000000;
      endcase
   end

   assign unit.go      = (st == ST_RUN);
   assign unit.srcAddr = srcAddr;
   assign unit.dstAddr = dstAddr;

   always_comb begin
      next_st            = st;
      next_srcAddr       = srcAddr;
      next_dstAddr       = dstAddr;
      next_blkSave       = blkSave;
      next_blockSizeHold = blockSizeHold;
      next_unitCnt       = unitCnt;
      next_blockCount    = blockCount;
      next_areaIsDst     = areaIsDst;
      next_srcMode       = srcMode;
      next_dstMode       = dstMode;
      next_irqFlag       = irqFlag;
      goReq              = 1'b0;
      irqSet             = 1'b0;
      // setup registers are frozen while a block runs
      if (regs.wrEn && st == ST_IDLE) begin
         case (regs.idx)
            IDX_SRC: next_srcAddr = regs.wrData;
            IDX_DST: next_dstAddr = regs.wrData;
            IDX_CRA: begin
               // zero in either byte stands for 256 units
               next_blockSizeHold = regs.wrData[CRA_HOLD_LSB +: 8];
               next_unitCnt       = regs.wrData[7:0];
            end
            IDX_CRB: next_blockCount = regs.wrData[15:0];
            IDX_CTRL: begin
               next_areaIsDst = regs.wrData[CTRL_AREA_BIT];
               next_srcMode   = regs.wrData[CTRL_SMODE_LSB +: 2];
               next_dstMode   = regs.wrData[CTRL_DMODE_LSB +: 2];
               goReq          = regs.wrData[CTRL_START_BIT];
            end
            default: ;
         endcase
      end
      case (st)
         ST_IDLE: begin
            if (goReq || actReq) begin
               next_blkSave = next_areaIsDst ? next_dstAddr : next_srcAddr;
               next_st      = ST_RUN;
            end
         end
         ST_RUN: next_st = ST_WAIT;
         ST_WAIT: begin
            if (unit.done) begin
               next_srcAddr = dte_step(srcAddr, srcMode);
               next_dstAddr = dte_step(dstAddr, dstMode);
               if (unitCnt == 8'h01) begin
                  next_st = ST_FIN;
               end else begin
                  // wraps from zero, so a zero count runs 256 units
                  next_unitCnt = unitCnt - 8'h01;
                  next_st      = ST_RUN;
               end
            end
         end
         ST_FIN: begin
            next_unitCnt = blockSizeHold;
            if (areaIsDst) begin
               next_dstAddr = blkSave;
            end else begin
               next_srcAddr = blkSave;
            end
            next_blockCount = blockCount - 16'h0001;
            irqSet          = (blockCount == 16'h0001);
            next_st         = ST_IDLE;
         end
         default: next_st = ST_IDLE;
      endcase
      // write one to clear; a set in the same cycle wins
      if (regs.wrEn && regs.idx == IDX_STAT && regs.wrData[STAT_IRQ_BIT]) begin
         next_irqFlag = 1'b0;
      end
      if (irqSet) begin
         next_irqFlag = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st            <= ST_IDLE;
         srcAddr       <= RST_ADDR;
         dstAddr       <= RST_ADDR;
         blkSave       <= RST_ADDR;
         blockSizeHold <= RST_SIZE;
         unitCnt       <= RST_SIZE;
         blockCount    <= RST_BLOCKS;
         areaIsDst     <= 1'b0;
         srcMode       <= AM_FIXED;
         dstMode       <= AM_FIXED;
         irqFlag       <= 1'b0;
      end else begin
         st            <= next_st;
         srcAddr       <= next_srcAddr;
         dstAddr       <= next_dstAddr;
         blkSave       <= next_blkSave;
         blockSizeHold <= next_blockSizeHold;
         unitCnt       <= next_unitCnt;
         blockCount    <= next_blockCount;
         areaIsDst     <= next_areaIsDst;
         srcMode       <= next_srcMode;
         dstMode       <= next_dstMode;
         irqFlag       <= next_irqFlag;
      end
   end

   assign cpuIrq = irqFlag;

   default clocking dteClk @(posedge clk);
   endclocking
   default disable iff (rst);

   start_to_run_a: assert property (
      (st == ST_IDLE && actReq) |=> (st == ST_RUN) ##1 (st == ST_WAIT))
      else $error("activation did not start a block");

   block_end_a: assert property (
      (st == ST_FIN) |-> ($past(unitCnt) == 8'h01 && $past(st) == ST_WAIT))
      else $error("block ended before its last unit");

   size_restore_a: assert property (
      (st == ST_FIN) |=> (unitCnt == $past(blockSizeHold) && st == ST_IDLE))
      else $error("unit counter not restored from held size");

   area_restore_a: assert property (
      (st == ST_FIN && !areaIsDst) |=> (srcAddr == $past(blkSave)))
      else $error("source block area not rewound");

   dst_restore_a: assert property (
      (st == ST_FIN && areaIsDst) |=> (dstAddr == $past(blkSave)))
      else $error("destination block area not rewound");

   dst_step_a: assert property (
      (st == ST_WAIT && unit.done && dstMode == AM_INC)
         |=> (dstAddr == $past(dstAddr) + ADDR_STEP))
      else $error("destination address did not step up");

   src_step_a: assert property (
      (st == ST_WAIT && unit.done && srcMode == AM_DEC)
         |=> (srcAddr == $past(srcAddr) - ADDR_STEP))
      else $error("source address did not step down");

   unit_count_a: assert property (
      (st == ST_WAIT && unit.done && unitCnt != 8'h01)
         |=> (unitCnt == $past(unitCnt) - 8'h01) ##1 (st == ST_WAIT))
      else $error("unit counter not decremented");

   block_count_a: assert property (
      (st == ST_FIN) |=> (blockCount == $past(blockCount) - 16'h0001))
      else $error("block count not decremented");

   irq_raise_a: assert property (
      (st == ST_FIN && blockCount == 16'h0001) |=> (cpuIrq && blockCount == 16'h0000))
      else $error("interrupt missing after last block");

   read_addr_a: assert property (
      $rose(memRead) |-> (memAddr == srcAddr && st == ST_WAIT))
      else $error("unit read not at source address");

   write_addr_a: assert property (
      $rose(memWrite) |-> (memAddr == dstAddr))
      else $error("unit write not at destination address");
endmodule : dte_top

// ---- test/dte_mem_model.sv ----
// behavioural memory behind the unit move port of the block transfer engine
// assumes: one request at a time, held until memAck; latency chosen by the bench
`timescale 1ns/1ps
module dte_mem_model
#(
   parameter int DATA_W = 16
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              memRead,
   input  wire logic              memWrite,
   input  wire logic [31:0]       memAddr,
   input  wire logic [DATA_W-1:0] memWdata,
   input  wire logic [3:0]        lat,
   output logic      [DATA_W-1:0] memRdata,
   output logic                   memAck
);
   logic [DATA_W-1:0] mem [0:511];
   logic [3:0]        waitCnt;

   initial begin
      memAck = 1'b0;
      memRdata = '0;
      waitCnt = 4'h0;
      for (int i = 0; i < 512; i++) begin
         mem[i] = DATA_W'(32'hA000 + i);
      end
   end

   // read data toggles outside the ack cycle so a late sample never matches
   always @(posedge clk) begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (rst) begin
         waitCnt <= 4'h0;
      end else if ((memRead || memWrite) && !memAck) begin
         if (waitCnt == lat) begin
            waitCnt <= 4'h0;
            memAck <= 1'b1;
            if (memRead) begin
               memRdata <= mem[memAddr[8:0]];
            end
            if (memWrite) begin
               mem[memAddr[8:0]] <= memWdata;
            end
         end else begin
            waitCnt <= waitCnt + 4'h1;
         end
      end
   end
endmodule : dte_mem_model

// ---- test/tb_top.sv ----
// self-checking bench of the block transfer engine
// assumes: dte_top with its memory port wired to the behavioural memory model
`timescale 1ns/1ps
module tb_top
   import dte_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  avsAddress = 5'h00;
   logic        avsRead = 1'b0;
   logic        avsWrite = 1'b0;
   logic [31:0] avsWritedata = 32'h00000000;
   logic [3:0]  avsByteenable = 4'hF;
   logic [31:0] avsReaddata;
   logic        avsWaitrequest;
   logic        actReq = 1'b0;
   logic        memRead;
   logic        memWrite;
   logic        memAck;
   logic [31:0] memAddr;
   logic [15:0] memWdata;
   logic [15:0] memRdata;
   logic        cpuIrq;
   logic [3:0]  lat = 4'h0;
   logic [31:0] rd;
   int          fails = 0;
   int          checked = 0;

   always #5 clk = ~clk;

   dte_top #(.DATA_W(16)) i_dut (
      .clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
      .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .actReq(actReq),
      .memRead(memRead), .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata),
      .memRdata(memRdata), .memAck(memAck), .cpuIrq(cpuIrq));

   dte_mem_model #(.DATA_W(16)) i_mem (
      .clk(clk), .rst(rst), .memRead(memRead), .memWrite(memWrite), .memAddr(memAddr),
      .memWdata(memWdata), .lat(lat), .memRdata(memRdata), .memAck(memAck));

   task automatic wrap_up;
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up

   task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chkReg

   task automatic chkMem(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t mem got=%h exp=%h", $time, got, exp);
      end
   endtask : chkMem

   function automatic logic [15:0] initVal(input int a);
      initVal = 16'hA000 + 16'(a);
   endfunction : initVal

   // entered just after a rising edge; waitrequest and read data sampled at rising edges
   task automatic busOp(input logic wr, input logic [2:0] idx, input logic [31:0] d,
                        input logic [3:0] be);
      int n;
      n = 0;
      avsAddress <= {idx, 2'b00};
      avsWrite <= wr;
      avsRead <= !wr;
      avsWritedata <= d;
      avsByteenable <= be;
      @(posedge clk);
      while (avsWaitrequest !== 1'b0) begin
         n++;
         if (n > 50) begin
            fails++;
            wrap_up();
         end
         @(posedge clk);
      end
      rd = avsReaddata;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      // idle edge keeps the next request from reassigning in this time step
      @(posedge clk);
   endtask : busOp

   task automatic regWr(input logic [2:0] idx, input logic [31:0] d);
      busOp(1'b1, idx, d, 4'hF);
   endtask : regWr

   task automatic regChk(input logic [2:0] idx, input logic [31:0] exp);
      busOp(1'b0, idx, 32'h00000000, 4'hF);
      chkReg(rd, exp);
   endtask : regChk

   task automatic waitIdle;
      int n;
      n = 0;
      do begin
         busOp(1'b0, IDX_STAT, 32'h00000000, 4'hF);
         n++;
         if (n > 2000) begin
            fails++;
            wrap_up();
         end
      end while (rd[STAT_BUSY_BIT] !== 1'b0);
   endtask : waitIdle

   function automatic logic [31:0] ctl(input logic area, input logic [1:0] sm,
                                       input logic [1:0] dm);
      ctl = 32'h00000001 | (32'(area) << CTRL_AREA_BIT) | (32'(sm) << CTRL_SMODE_LSB)
            | (32'(dm) << CTRL_DMODE_LSB);
   endfunction : ctl

   task automatic cfg(input logic [31:0] s, input logic [31:0] d, input logic [31:0] a,
                      input logic [31:0] b);
      regWr(IDX_SRC, s);
      regWr(IDX_DST, d);
      regWr(IDX_CRA, a);
      regWr(IDX_CRB, b);
   endtask : cfg

   initial begin
      int st;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      regChk(IDX_SRC, 32'h00000000);
      regChk(IDX_DST, 32'h00000000);
      regChk(IDX_CRA, 32'h00000101);
      regChk(IDX_CRB, 32'h00000001);
      regChk(IDX_CTRL, 32'h00000000);
      regChk(IDX_STAT, 32'h00000000);
      regWr(3'h7, 32'hFFFFFFFF);
      regChk(3'h7, 32'h00000000);
      regWr(IDX_SRC, 32'h11111111);
      busOp(1'b1, IDX_SRC, 32'h22222222, 4'h3);
      regChk(IDX_SRC, 32'h11112222);
      // two blocks of four, source as block area, second started by actReq
      cfg(32'h00000010, 32'h00000040, 32'h00000404, 32'h00000002);
      regWr(IDX_CTRL, ctl(1'b0, AM_INC, AM_INC));
      waitIdle();
      regChk(IDX_SRC, 32'h00000010);
      regChk(IDX_DST, 32'h00000044);
      regChk(IDX_CRA, 32'h00000404);
      regChk(IDX_CRB, 32'h00000001);
      chkReg({31'h0, cpuIrq}, 32'h00000000);
      lat <= 4'h3;
      actReq <= 1'b1;
      @(posedge clk);
      actReq <= 1'b0;
      waitIdle();
      regChk(IDX_DST, 32'h00000048);
      regChk(IDX_CRB, 32'h00000000);
      regChk(IDX_STAT, 32'h00000002);
      chkReg({31'h0, cpuIrq}, 32'h00000001);
      for (int i = 0; i < 8; i++) begin
         chkMem(i_mem.mem[9'h040 + i], initVal(16 + i % 4));
      end
      regWr(IDX_STAT, 32'h00000002);
      chkReg({31'h0, cpuIrq}, 32'h00000000);
      // 256 units, one block from a zero block count, destination as block area; setup refused while busy
      lat <= 4'h1;
      cfg(32'h00000000, 32'h00000100, 32'h00000000, 32'h00000000);
      regWr(IDX_CTRL, ctl(1'b1, AM_INC, AM_INC));
      regWr(IDX_SRC, 32'h0000001F);
      regChk(IDX_STAT, 32'h00000001);
      waitIdle();
      regChk(IDX_SRC, 32'h00000100);
      regChk(IDX_DST, 32'h00000100);
      regChk(IDX_CRA, 32'h00000000);
      regChk(IDX_CRB, 32'h0000FFFF);
      regChk(IDX_STAT, 32'h00000000);
      for (int i = 0; i < 256; i++) begin
         // words 0x40..0x47 still hold what the first scenario wrote there
         chkMem(i_mem.mem[9'h100 + i], initVal((i >> 3) == 8 ? 16 + i % 4 : i));
      end
      // every address mode on the non-area side, both area choices
      lat <= 4'h2;
      for (int a = 0; a < 2; a++) begin
         for (int m = 0; m < 4; m++) begin
            st = (m == 1) ? 1 : ((m == 2) ? -1 : 0);
            cfg(32'h00000030, 32'h000001C0, 32'h00000202, 32'h00000001);
            if (a == 0) regWr(IDX_CTRL, ctl(1'b0, AM_INC, 2'(m)));
            else regWr(IDX_CTRL, ctl(1'b1, 2'(m), AM_INC));
            waitIdle();
            if (a == 0) begin
               regChk(IDX_SRC, 32'h00000030);
               regChk(IDX_DST, 32'h000001C0 + 32'(2 * st));
               chkMem(i_mem.mem[9'h1C0 + st], initVal(16'h31));
            end else begin
               regChk(IDX_SRC, 32'h00000030 + 32'(2 * st));
               regChk(IDX_DST, 32'h000001C0);
               chkMem(i_mem.mem[9'h1C1], initVal(16'h30 + st));
            end
            regChk(IDX_STAT, 32'h00000002);
            regWr(IDX_STAT, 32'h00000002);
         end
      end
      regChk(IDX_STAT, 32'h00000000);
      wrap_up();
   end
endmodule : tb_top
